//--- src/gifl_regs.sv
// The AXI4-Lite register port was decided locally.
module gifl_regs #(
  parameter logic [gifl_pkg::RELOFF_W-1:0] PORT_OFFSET = 10'h000,
  parameter logic [gifl_pkg::NPIN-1:0] IMPL_MASK = 32'hFFFF_FFFF,
  parameter logic [gifl_pkg::NPIN-1:0] GLITCH_RESET = 32'h0000_0000,
  // arbitrary value
  parameter logic [11:0] REV_NUMBER = 12'h101,
  // arbitrary value
  parameter logic [3:0] REV_VARIANT = 4'h0
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [gifl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [gifl_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [gifl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [gifl_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and events
  input wire logic [gifl_pkg::NPIN-1:0] pin_level,
  output logic [gifl_pkg::NPIN-1:0] pin_event
);
  import gifl_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [DATA_W-1:0] rdata_q, w_data_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [3:0] w_strb_q;
  logic [NPIN-1:0] ctl_q [NCTL];
  logic [NPIN-1:0] protect_q, flag_q, flag_d, pin_event_q, pin_sync;
  logic access_err_q, access_err_d, armed_q;
  logic [RELOFF_W-1:0] armed_off_q;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] ctl_slot(input logic [8:0] base);
    unique case (base)
      OFF_IRQ_EN: ctl_slot = {1'b1, IDX_IRQ_EN};
      OFF_MODE_LO: ctl_slot = {1'b1, IDX_MODE_LO};
      OFF_MODE_HI: ctl_slot = {1'b1, IDX_MODE_HI};
      OFF_GLITCH: ctl_slot = {1'b1, IDX_GLITCH};
      OFF_EVENT: ctl_slot = {1'b1, IDX_EVENT};
      default: ctl_slot = 4'h0;
    endcase
  endfunction : ctl_slot
  function automatic logic [31:0] apply_alias(input logic [31:0] cur, input logic [31:0] wd,
                                              input logic [31:0] m, input logic [1:0] kind);
    unique case (kind)
      ALIAS_RW: apply_alias = (cur & ~m) | (wd & m);
      ALIAS_SET: apply_alias = cur | (wd & m);
      ALIAS_CLR: apply_alias = cur & ~(wd & m);
      ALIAS_TGL: apply_alias = cur ^ (wd & m);
    endcase
  endfunction : apply_alias

  // ----------------------------------------------------------------
  // pin path
  // ----------------------------------------------------------------
  gifl_pin_if pif ();
  gifl_pin_sync u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pin_raw(pin_level),
    .pin_sync(pin_sync)
  );
  assign pif.level = pin_sync;
  assign pif.filt_en = ctl_q[IDX_GLITCH];
  assign pif.mode_lo = ctl_q[IDX_MODE_LO];
  assign pif.mode_hi = ctl_q[IDX_MODE_HI];
  gifl_pin_detect u_detect (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .pif(pif)
  );

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic wr_go, wr_ctl, wr_prot, prot_pass, wr_release, key_ok, wr_known, err_set;
  logic [8:0] wr_base, wr_word;
  logic [1:0] wr_alias;
  logic [3:0] wr_slot;
  logic [2:0] wr_idx;
  logic [31:0] wr_mask, wr_bits, ctl_cur, ctl_new, ctl_kept, viol_bits;
  assign wr_go = !awready_q && !wready_q && !bvalid_q;
  always_comb begin
    wr_base = {aw_addr_q[ADDR_W-1:4], 4'h0};
    wr_word = {aw_addr_q[ADDR_W-1:2], 2'h0};
    wr_alias = aw_addr_q[3:2];
    wr_slot = ctl_slot(wr_base);
    wr_idx = wr_slot[2:0];
    wr_ctl = wr_go && wr_slot[3];
    for (int b = 0; b < 4; b++) begin
      wr_mask[8*b +: 8] = {8{w_strb_q[b]}};
    end
    wr_bits = w_data_q & wr_mask;
    ctl_cur = ctl_q[wr_idx];
    ctl_new = apply_alias(ctl_cur, w_data_q, wr_mask, wr_alias);
    viol_bits = (ctl_new ^ ctl_cur) & protect_q;
    ctl_kept = (ctl_new & ~protect_q) | (ctl_cur & protect_q);
    wr_prot = wr_go && (wr_base == OFF_PROTECT);
    // the offset field carries the port's own offset too
    prot_pass = (wr_alias == ALIAS_SET) ||
                (armed_q && (armed_off_q == RELOFF_W'(PORT_OFFSET + {1'b0, wr_word})));
    wr_release = wr_go && (wr_word == OFF_RELEASE);
    key_ok = (w_data_q[KEY_MSB:KEY_LSB] == KEY_VALUE);
    wr_known = wr_slot[3] || (wr_base == OFF_PROTECT) || (wr_word == OFF_FLAG) ||
               (wr_word == OFF_FLAG_CLR) || (wr_word == OFF_RELEASE) ||
               (wr_word == OFF_STATUS) || (wr_word == OFF_IMPL) || (wr_word == OFF_REV);
    err_set = (wr_ctl && (viol_bits != '0)) || (wr_prot && !prot_pass);
  end

  // ----------------------------------------------------------------
  // axi write channels
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        wready_q <= 1'b0;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // lockable per-pin registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < NCTL; k++) begin
        ctl_q[k] <= (k == int'(IDX_GLITCH)) ? GLITCH_RESET : RST_WORD;
      end
    end else if (ce && wr_ctl) begin
      ctl_q[wr_idx] <= ctl_kept;
    end
  end

  // ----------------------------------------------------------------
  // protection and key sequence
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      protect_q <= RST_WORD;
    end else if (ce && wr_prot && prot_pass) begin
      protect_q <= apply_alias(protect_q, w_data_q, wr_mask, wr_alias);
    end
  end

  // any write spends the arming; only a good key write re-arms
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_q <= 1'b0;
      armed_off_q <= '0;
    end else if (ce && wr_go) begin
      armed_q <= wr_release && key_ok;
      armed_off_q <= w_data_q[RELOFF_MSB:RELOFF_LSB];
    end
  end
  always_comb begin
    access_err_d = access_err_q;
    if (wr_go && (wr_word == OFF_STATUS) && w_strb_q[0] && !w_data_q[ERR_BIT]) begin
      access_err_d = 1'b0;
    end
    // a new violation outranks the software clear
    if (err_set) begin
      access_err_d = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      access_err_q <= 1'b0;
    end else if (ce) begin
      access_err_q <= access_err_d;
    end
  end

  // ----------------------------------------------------------------
  // flags and events
  // ----------------------------------------------------------------
  always_comb begin
    flag_d = flag_q;
    if (wr_go && (wr_word == OFF_FLAG_CLR)) begin
      flag_d = flag_q & ~wr_bits;
    end
    flag_d = flag_d | (pif.hit & ctl_q[IDX_IRQ_EN]);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= RST_WORD;
      pin_event_q <= RST_WORD;
    end else if (ce) begin
      flag_q <= flag_d;
      pin_event_q <= pif.hit & ctl_q[IDX_EVENT];
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  logic [8:0] rd_word;
  logic [3:0] rd_slot;
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_word = {s_axi_araddr[ADDR_W-1:2], 2'h0};
    rd_slot = ctl_slot({s_axi_araddr[ADDR_W-1:4], 4'h0});
    rd_val = RST_WORD;
    rd_ok = 1'b1;
    if (rd_slot[3]) begin
      rd_val = ctl_q[rd_slot[2:0]];
    end else if ({s_axi_araddr[ADDR_W-1:4], 4'h0} == OFF_PROTECT) begin
      rd_val = protect_q;
    end else begin
      case (rd_word)
        OFF_FLAG: rd_val = flag_q;
        OFF_FLAG_CLR: rd_val = flag_q;
        OFF_RELEASE: rd_val = RST_WORD;
        OFF_STATUS: rd_val[ERR_BIT] = access_err_q;
        OFF_IMPL: rd_val = IMPL_MASK;
        OFF_REV: begin
          rd_val[REV_LSB +: 12] = REV_NUMBER;
          rd_val[VARIANT_LSB +: 4] = REV_VARIANT;
        end
        default: rd_ok = 1'b0;
      endcase
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= RST_WORD;
    end else if (ce) begin
      if (s_axi_arvalid && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_val;
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign pin_event = pin_event_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_release_reads_zero: assert property (
    (ce && s_axi_arvalid && arready_q && rd_word == OFF_RELEASE) |=> (rvalid_q && rdata_q == 32'h0000_0000))
    else $error("key register read not zero");
  chk_impl_mask_read: assert property (
    (ce && s_axi_arvalid && arready_q && rd_word == OFF_IMPL) |=> (rdata_q == IMPL_MASK && rresp_q == RESP_OKAY))
    else $error("implemented mask read wrong");
  chk_rev_read: assert property (
    (ce && s_axi_arvalid && arready_q && rd_word == OFF_REV) |=> (rdata_q[11:0] == REV_NUMBER &&
      rdata_q[19:16] == REV_VARIANT && rdata_q[31:20] == 12'h000 && rdata_q[15:12] == 4'h0))
    else $error("revision read wrong");
  chk_flag_sticky: assert property (
    !(wr_go && wr_word == OFF_FLAG_CLR) |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
    else $error("flag dropped without clear");
  chk_flag_set: assert property (
    (ce && (pif.hit & ctl_q[IDX_IRQ_EN]) != '0) |=> ((flag_q & $past(pif.hit)) != '0))
    else $error("enabled hit did not set flag");
  chk_event_gate: assert property (
    ce |=> ((pin_event_q & ~$past(ctl_q[IDX_EVENT])) == '0))
    else $error("event from disabled pin");
  chk_locked_hold: assert property (
    (ce && wr_ctl) |=> (((ctl_q[$past(wr_idx)] ^ $past(ctl_cur)) & $past(protect_q)) == '0))
    else $error("protected bit changed");
  chk_error_on_block: assert property (
    (ce && wr_ctl && viol_bits != '0) |=> access_err_q ##1 (access_err_q || $past(wr_go)))
    else $error("access error not raised");
  chk_protect_refused: assert property (
    (ce && wr_prot && wr_alias != ALIAS_SET && !armed_q) |=> (protect_q == $past(protect_q) && access_err_q))
    else $error("unarmed protect write took effect");
  chk_set_alias_free: assert property (
    (ce && wr_prot && wr_alias == ALIAS_SET) |=> ((protect_q & $past(wr_bits)) == $past(wr_bits)))
    else $error("set alias refused");
  chk_bad_key: assert property (
    (ce && wr_release && !key_ok) |=> !armed_q)
    else $error("bad key armed protection");
  cov_armed_write: cover property (ce && wr_prot && wr_alias != ALIAS_SET && prot_pass);
  cov_flag_set: cover property (ce && (pif.hit & ctl_q[IDX_IRQ_EN]) != '0);
  cov_toggle_alias: cover property (ce && wr_ctl && wr_alias == ALIAS_TGL);
  cov_blocked_write: cover property (ce && wr_ctl && viol_bits != '0);

endmodule : gifl_regs

//--- src/gifl_pkg.sv
package gifl_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NPIN = 32;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int NCTL = 5;
  localparam int RELOFF_W = 10;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [8:0] OFF_IRQ_EN = 9'h090;
  localparam logic [8:0] OFF_MODE_LO = 9'h0A0;
  localparam logic [8:0] OFF_MODE_HI = 9'h0B0;
  localparam logic [8:0] OFF_GLITCH = 9'h0C0;
  localparam logic [8:0] OFF_FLAG = 9'h0D0;
  localparam logic [8:0] OFF_FLAG_CLR = 9'h0D8;
  localparam logic [8:0] OFF_EVENT = 9'h180;
  localparam logic [8:0] OFF_PROTECT = 9'h1A0;
  localparam logic [8:0] OFF_RELEASE = 9'h1E0;
  localparam logic [8:0] OFF_STATUS = 9'h1E4;
  localparam logic [8:0] OFF_IMPL = 9'h1F8;
  localparam logic [8:0] OFF_REV = 9'h1FC;

  // ----------------------------------------------------------------
  // slots of the lockable per-pin registers
  // ----------------------------------------------------------------
  localparam logic [2:0] IDX_IRQ_EN = 3'h0;
  localparam logic [2:0] IDX_MODE_LO = 3'h1;
  localparam logic [2:0] IDX_MODE_HI = 3'h2;
  localparam logic [2:0] IDX_GLITCH = 3'h3;
  localparam logic [2:0] IDX_EVENT = 3'h4;

  // ----------------------------------------------------------------
  // alias kinds, modes, fields, responses
  // ----------------------------------------------------------------
  localparam logic [1:0] ALIAS_RW = 2'h0;
  localparam logic [1:0] ALIAS_SET = 2'h1;
  localparam logic [1:0] ALIAS_CLR = 2'h2;
  localparam logic [1:0] ALIAS_TGL = 2'h3;
  localparam logic [1:0] MODE_CHANGE = 2'h0;
  localparam logic [1:0] MODE_RISE = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam int KEY_MSB = 31;
  localparam int KEY_LSB = 24;
  localparam logic [7:0] KEY_VALUE = 8'hAA;
  localparam int RELOFF_MSB = 9;
  localparam int RELOFF_LSB = 0;
  localparam int ERR_BIT = 0;
  localparam int REV_LSB = 0;
  localparam int VARIANT_LSB = 16;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gifl_pkg

//--- src/gifl_pin_if.sv
interface gifl_pin_if;
  logic [gifl_pkg::NPIN-1:0] level;
  logic [gifl_pkg::NPIN-1:0] filt_en;
  logic [gifl_pkg::NPIN-1:0] mode_lo;
  logic [gifl_pkg::NPIN-1:0] mode_hi;
  logic [gifl_pkg::NPIN-1:0] hit;
  modport det (input level, input filt_en, input mode_lo, input mode_hi, output hit);
  modport ctl (output level, output filt_en, output mode_lo, output mode_hi, input hit);
endinterface : gifl_pin_if

//--- src/gifl_pin_sync.sv
module gifl_pin_sync (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // pins
  input wire logic [gifl_pkg::NPIN-1:0] pin_raw,
  output logic [gifl_pkg::NPIN-1:0] pin_sync
);
  import gifl_pkg::*;

  // ----------------------------------------------------------------
  // two-stage synchroniser per pin
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NPIN; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else if (ce) begin
        meta_q <= pin_raw[i];
        sync_q <= meta_q;
      end
    end
    assign pin_sync[i] = sync_q;
  end

endmodule : gifl_pin_sync

//--- src/gifl_pin_detect.sv
module gifl_pin_detect (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // pin conditions
  gifl_pin_if.det pif
);
  import gifl_pkg::*;

  // ----------------------------------------------------------------
  // filter and edge detection per pin
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    logic prev_q;
    logic lvl_q;
    logic hit_q;
    logic lvl_d;
    logic rise;
    logic fall;
    logic cond;
    always_comb begin
      // filtered level only moves after two equal samples
      lvl_d = (pif.filt_en[i] && (pif.level[i] != prev_q)) ? lvl_q : pif.level[i];
      rise = lvl_d & ~lvl_q;
      fall = ~lvl_d & lvl_q;
      unique case ({pif.mode_hi[i], pif.mode_lo[i]})
        MODE_CHANGE: cond = rise | fall;
        MODE_RISE: cond = rise;
        MODE_FALL: cond = fall;
        MODE_RSVD: cond = 1'b0;
      endcase
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        prev_q <= 1'b0;
        lvl_q <= 1'b0;
        hit_q <= 1'b0;
      end else if (ce) begin
        prev_q <= pif.level[i];
        lvl_q <= lvl_d;
        hit_q <= cond;
      end
    end
    assign pif.hit[i] = hit_q;

    chk_reserved_no_hit: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && pif.mode_hi[i] && pif.mode_lo[i]) |=> !hit_q)
      else $error("hit raised in reserved mode");
    chk_bypass_change: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && !pif.filt_en[i] && !pif.mode_hi[i] && !pif.mode_lo[i] && pif.level[i] != lvl_q) |=> hit_q)
      else $error("unfiltered change missed");
  end

endmodule : gifl_pin_detect

//--- verification/gifl_pin_model.sv
module gifl_pin_model (
  // clock
  input wire logic aclk,
  // pins and events
  input wire logic [31:0] pin_event,
  output logic [31:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  int ev_cnt [32];

  initial begin
    pin_level = 32'h0000_0000;
    foreach (ev_cnt[i]) ev_cnt[i] = 0;
  end

  // levels move just after an edge and are held a whole cycle
  task automatic set_pins(input logic [31:0] v);
    @(posedge aclk);
    pin_level <= v;
  endtask : set_pins

  // event system side: one pulse counts one event
  always @(posedge aclk) begin
    for (int i = 0; i < 32; i++) begin
      if (pin_event[i] === 1'b1) ev_cnt[i]++;
    end
  end
endmodule : gifl_pin_model

//--- verification/test_gifl_regs.sv
module test_gifl_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import gifl_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] wstrb;
  logic [8:0] awaddr, araddr;
  logic [31:0] wdata, rdata, pin_level, pin_event;
  logic [1:0] bresp, rresp;
  int n_errors, checked;

  // rev values are arbitrary
  gifl_regs #(.PORT_OFFSET(10'h200), .IMPL_MASK(32'h00FF_FFFF), .REV_NUMBER(12'h2A5), .REV_VARIANT(4'h3)) dut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_level(pin_level), .pin_event(pin_event));
  gifl_pin_model pm (.aclk(aclk), .pin_event(pin_event), .pin_level(pin_level));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        done = 1;
        chk({30'h0, bresp}, {30'h0, RESP_OKAY});
      end
    end
  endtask : wr

  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    bit done;
    done = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        done = 1;
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
      end
    end
  endtask : rd_chk

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // clock, timeout
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial begin
    repeat (4000) @(posedge aclk);
    n_errors++;
    $display("mismatch at %0t: timeout", $time);
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    wstrb = 4'hF;
    awaddr = 9'h000;
    araddr = 9'h000;
    wdata = 32'h0000_0000;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(OFF_IMPL, 32'h00FF_FFFF);
    wr(OFF_IMPL, 32'h0000_0000);
    rd_chk(OFF_IMPL, 32'h00FF_FFFF);
    rd_chk(OFF_REV, 32'h0003_02A5);
    rd_chk(OFF_GLITCH, 32'h0000_0000);
    rd_chk(9'h100, 32'h0000_0000, RESP_SLVERR);
    wr(OFF_RELEASE, 32'hAA00_03A0);
    rd_chk(OFF_RELEASE, 32'h0000_0000);
    // write, set, clear, toggle aliases
    wr(OFF_EVENT, 32'h0000_000F);
    wr(OFF_EVENT + 9'h004, 32'h0000_00F0);
    wr(OFF_EVENT + 9'h008, 32'h0000_0003);
    wr(OFF_EVENT + 9'h00C, 32'h0000_0101);
    rd_chk(OFF_EVENT + 9'h008, 32'h0000_01FD);
    wr(OFF_EVENT, 32'h0000_0001);
    // pin0 change, pin1 rise, pin2 fall, pin3 reserved, pin4 irq off
    wr(OFF_IRQ_EN, 32'h0000_000F);
    wr(OFF_MODE_LO, 32'h0000_000A);
    wr(OFF_MODE_HI, 32'h0000_000C);
    pm.set_pins(32'h0000_001F);
    repeat (8) @(posedge aclk);
    rd_chk(OFF_FLAG, 32'h0000_0003);
    rd_chk(OFF_FLAG, 32'h0000_0003);
    wr(OFF_FLAG_CLR, 32'h0000_000F);
    rd_chk(OFF_FLAG, 32'h0000_0000);
    pm.set_pins(32'h0000_0000);
    repeat (8) @(posedge aclk);
    rd_chk(OFF_FLAG, 32'h0000_0005);
    wr(OFF_FLAG_CLR, 32'h0000_000F);
    chk(pm.ev_cnt[0], 32'd2);
    chk(pm.ev_cnt[1], 32'd0);
    // filter set while irq still off; single-cycle pulse on 4 and 5
    wr(OFF_GLITCH + 9'h004, 32'h0000_0010);
    wr(OFF_IRQ_EN + 9'h004, 32'h0000_0030);
    pm.set_pins(32'h0000_0030);
    pm.set_pins(32'h0000_0000);
    repeat (8) @(posedge aclk);
    rd_chk(OFF_FLAG, 32'h0000_0020);
    wr(OFF_FLAG_CLR, 32'h0000_0020);
    // frozen while ce is low: the same pulse must go unseen
    ce <= 1'b0;
    pm.set_pins(32'h0000_0020);
    pm.set_pins(32'h0000_0000);
    ce <= 1'b1;
    repeat (8) @(posedge aclk);
    rd_chk(OFF_FLAG, 32'h0000_0000);
    // pin protection
    wr(OFF_PROTECT + 9'h004, 32'h0000_0001);
    wr(OFF_IRQ_EN, 32'h0000_0000);
    rd_chk(OFF_IRQ_EN, 32'h0000_0001);
    rd_chk(OFF_STATUS, 32'h0000_0001);
    wr(OFF_STATUS, 32'h0000_0000);
    rd_chk(OFF_STATUS, 32'h0000_0000);
    wr(OFF_PROTECT + 9'h008, 32'h0000_0001);
    wr(OFF_RELEASE, 32'hAB00_03A8);
    wr(OFF_PROTECT + 9'h008, 32'h0000_0001);
    rd_chk(OFF_PROTECT, 32'h0000_0001);
    wr(OFF_RELEASE, 32'hAA00_01A8);
    wr(OFF_PROTECT + 9'h008, 32'h0000_0001);
    rd_chk(OFF_PROTECT, 32'h0000_0001);
    wr(OFF_RELEASE, 32'hAA00_03AC);
    wr(OFF_EVENT, 32'h0000_0001);
    wr(OFF_PROTECT + 9'h00C, 32'h0000_0001);
    rd_chk(OFF_PROTECT, 32'h0000_0001);
    rd_chk(OFF_STATUS, 32'h0000_0001);
    wr(OFF_RELEASE, 32'hAA00_03AC);
    wr(OFF_PROTECT + 9'h00C, 32'h0000_0001);
    rd_chk(OFF_PROTECT, 32'h0000_0000);
    wr(OFF_IRQ_EN, 32'h0000_0000);
    rd_chk(OFF_IRQ_EN, 32'h0000_0000);
    // byte strobes: only byte one of the filter enables moves, status clear needs byte zero
    wstrb <= 4'h2;
    wr(OFF_GLITCH, 32'hFFFF_FFFF);
    rd_chk(OFF_GLITCH, 32'h0000_FF10);
    wr(OFF_STATUS, 32'h0000_0000);
    rd_chk(OFF_STATUS, 32'h0000_0001);
    wstrb <= 4'hF;
    wr(OFF_STATUS, 32'h0000_0000);
    rd_chk(OFF_STATUS, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : test_gifl_regs
